// ---- hdl/fps_supervisor.sv ----
/*
  Fault protection supervisor with an AXI4-Lite register slave.
  Assumes all measurement inputs come from converter logic on ref_clk_i.
*/
// Local design decisions: the AXI4-Lite register port and the placing of the registers.
// Behaviour
// - Overcurrent trip 40..140 percent, eleven steps, default 140
// - Overvoltage trip 110..130 percent, default 130
// - Overvoltage trip never below one volt
// - Undervoltage trip 75..90 percent in 5 percent steps
// - Overvoltage, undervoltage, tracking turn off after 6 us
// - Shut down at 120 C, restart at or below 110 C
// - Overtemperature turn off after 2 ms
// - Tracking off by default, ramp-up only, 250 mV
// - Warning flag at 120 C, 3 C hysteresis
// - Warning flag asserts 6 us after threshold
// - Power good window 90/95 to 110 percent
// - Power good changes 6 us after crossing
`timescale 1ns/1ps
module fps_supervisor
  import fps_pkg::*;
#(
  parameter logic [23:0] OT_DLY = 24'(OT_DLY_CYC),
  parameter logic [23:0] RETRY_DLY = 24'(RETRY_CYC)
)
(
  // Clock and reset.
  input wire logic ref_clk_i,
  input wire logic nrst_i,
  // AXI4-Lite slave.
  input wire logic [3:0] awaddr_i,
  input wire logic awvalid_i,
  output logic awready_o,
  input wire logic [31:0] wdata_i,
  input wire logic [3:0] wstrb_i,
  input wire logic wvalid_i,
  output logic wready_o,
  output logic [1:0] bresp_o,
  output logic bvalid_o,
  input wire logic bready_i,
  input wire logic [3:0] araddr_i,
  input wire logic arvalid_i,
  output logic arready_o,
  output logic [31:0] rdata_o,
  output logic [1:0] rresp_o,
  output logic rvalid_o,
  input wire logic rready_i,
  // Measurements.
  input wire logic [15:0] vout_mv_i,
  input wire logic [15:0] vset_mv_i,
  input wire logic [15:0] vtrack_mv_i,
  input wire logic [7:0] iout_pct_i,
  input wire logic [7:0] temp_c_i,
  input wire logic ramp_up_i,
  // Protection outputs.
  output logic turn_off_o,
  output logic power_good_output_o,
  output logic ot_warning_o
);

  typedef struct packed {
    logic aw_got;
    logic [3:0] awaddr;
    logic w_got;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic [14:0] ctrl;
    logic [4:0] cause;
    fps_mode_t mode;
    logic ot_off;
    logic [23:0] retry_cnt;
    logic [23:0] ov_cnt;
    logic [23:0] uv_cnt;
    logic [23:0] trk_cnt;
    logic [23:0] ot_cnt;
    logic [23:0] otw_cnt;
    logic [23:0] pg_cnt;
    logic otw;
    logic pg;
  } fps_state_t;

  fps_state_t st_reg;
  fps_state_t st_next;

  // Counts cycles while a condition holds, saturating at the limit.
  function automatic logic [23:0] fps_dstep(input logic [23:0] c, input logic cond,
                                            input logic [23:0] lim);
    fps_dstep = !cond ? 24'h0 : ((c >= lim) ? lim : c + 24'h1);
  endfunction

  // Product of a millivolt value and a percentage.
  function automatic logic [31:0] fps_mulp(input logic [15:0] mv, input logic [7:0] pct);
    fps_mulp = {16'h0, mv} * {24'h0, pct};
  endfunction

  logic run;
  logic [7:0] oc_pct;
  logic [7:0] ov_pct;
  logic [7:0] uv_pct;
  logic [7:0] pg_lo_pct;
  logic [31:0] vout_x100;
  logic [31:0] ov_thr;
  logic [16:0] trk_err;
  logic oc_cond;
  logic ov_cond;
  logic uv_cond;
  logic ot_cond;
  logic trk_cond;
  logic otw_cond;
  logic pg_inside;
  logic [4:0] trips;
  logic wr_do;
  logic [31:0] status;

  always_comb
  begin
    run = (st_reg.mode == ST_RUN);
    oc_pct = (st_reg.ctrl[F_OC+:4] >= OC_MAXCODE) ?
             8'(OC_MIN_PCT + OC_STEP * OC_MAXCODE) :
             8'(OC_MIN_PCT + OC_STEP * st_reg.ctrl[F_OC+:4]);
    ov_pct = (st_reg.ctrl[F_OV+:2] >= OV_MAXCODE) ?
             8'(OV_MIN_PCT + OV_STEP * OV_MAXCODE) :
             8'(OV_MIN_PCT + OV_STEP * st_reg.ctrl[F_OV+:2]);
    uv_pct = 8'(UV_MIN_PCT + UV_STEP * st_reg.ctrl[F_UV+:2]);
    pg_lo_pct = 8'(PG_LO_PCT + PG_STEP * st_reg.ctrl[F_PG]);
    vout_x100 = fps_mulp(vout_mv_i, 8'h64);
    ov_thr = fps_mulp(vset_mv_i, ov_pct);
    if (ov_thr < OV_FLOOR_X100)
    begin
      ov_thr = OV_FLOOR_X100;
    end
    if (vout_mv_i >= vtrack_mv_i)
    begin
      trk_err = {1'b0, vout_mv_i} - {1'b0, vtrack_mv_i};
    end
    else
    begin
      trk_err = {1'b0, vtrack_mv_i} - {1'b0, vout_mv_i};
    end
    oc_cond = run && (iout_pct_i > oc_pct);
    ov_cond = run && (vout_x100 > ov_thr);
    // Undervoltage is masked while the output is still ramping up.
    uv_cond = run && !ramp_up_i && (vout_x100 < fps_mulp(vset_mv_i, uv_pct));
    ot_cond = run && ($signed(temp_c_i) >= OT_OFF_C);
    trk_cond = run && st_reg.ctrl[F_TRK_EN] && ramp_up_i && (trk_err > TRK_MV);
    otw_cond = st_reg.otw ? ($signed(temp_c_i) <= OTW_CLR_C) :
               ($signed(temp_c_i) >= OTW_C);
    pg_inside = (vout_x100 >= fps_mulp(vset_mv_i, pg_lo_pct)) &&
                (vout_x100 <= fps_mulp(vset_mv_i, PG_HI_PCT));
    trips = 5'h0;
    trips[C_OC] = oc_cond;
    trips[C_OV] = run && (st_reg.ov_cnt == DLY_CYC);
    trips[C_UV] = run && (st_reg.uv_cnt == DLY_CYC);
    trips[C_OT] = run && (st_reg.ot_cnt == OT_DLY);
    trips[C_TRK] = run && (st_reg.trk_cnt == DLY_CYC);
    wr_do = st_reg.aw_got && st_reg.w_got && !st_reg.bvalid;
    status = {23'h0, (st_reg.mode == ST_LATCH), !run, st_reg.pg, st_reg.otw, st_reg.cause};
  end

  always_comb
  begin
    st_next = st_reg;
    // Register bus.
    if (awvalid_i && awready_o)
    begin
      st_next.aw_got = 1'b1;
      st_next.awaddr = awaddr_i;
    end
    if (wvalid_i && wready_o)
    begin
      st_next.w_got = 1'b1;
      st_next.wdata = wdata_i;
      st_next.wstrb = wstrb_i;
    end
    if (st_reg.bvalid && bready_i)
    begin
      st_next.bvalid = 1'b0;
    end
    if (wr_do)
    begin
      st_next.aw_got = 1'b0;
      st_next.w_got = 1'b0;
      st_next.bvalid = 1'b1;
      st_next.bresp = RESP_OKAY;
      case (st_reg.awaddr)
        ADDR_CTRL:
        begin
          if (st_reg.wstrb[0])
          begin
            st_next.ctrl[7:0] = st_reg.wdata[7:0];
          end
          if (st_reg.wstrb[1])
          begin
            st_next.ctrl[14:8] = st_reg.wdata[14:8];
          end
        end
        ADDR_STATUS:
        begin
          st_next.bresp = RESP_OKAY;
        end
        ADDR_CMD:
        begin
          if (st_reg.wstrb[0] && st_reg.wdata[F_CLR_CAUSE])
          begin
            st_next.cause = 5'h0;
          end
          if (st_reg.wstrb[0] && st_reg.wdata[F_REARM] && st_reg.mode == ST_LATCH)
          begin
            // Re-enable goes through the retry gate so a hot part stays off.
            st_next.mode = ST_RETRY;
            st_next.retry_cnt = RETRY_DLY;
          end
        end
        default:
        begin
          st_next.bresp = RESP_SLVERR;
        end
      endcase
    end
    if (st_reg.rvalid && rready_i)
    begin
      st_next.rvalid = 1'b0;
    end
    if (arvalid_i && arready_o)
    begin
      st_next.rvalid = 1'b1;
      st_next.rresp = RESP_OKAY;
      case (araddr_i)
        ADDR_CTRL:
        begin
          st_next.rdata = {17'h0, st_reg.ctrl};
        end
        ADDR_STATUS:
        begin
          st_next.rdata = status;
        end
        ADDR_CMD:
        begin
          st_next.rdata = 32'h0;
        end
        default:
        begin
          st_next.rdata = 32'h0;
          st_next.rresp = RESP_SLVERR;
        end
      endcase
    end
    // Detection delay filters.
    st_next.ov_cnt = fps_dstep(st_reg.ov_cnt, ov_cond, DLY_CYC);
    st_next.uv_cnt = fps_dstep(st_reg.uv_cnt, uv_cond, DLY_CYC);
    st_next.trk_cnt = fps_dstep(st_reg.trk_cnt, trk_cond, DLY_CYC);
    st_next.ot_cnt = fps_dstep(st_reg.ot_cnt, ot_cond, OT_DLY);
    st_next.otw_cnt = fps_dstep(st_reg.otw_cnt, otw_cond, DLY_CYC);
    if (st_reg.otw_cnt == DLY_CYC)
    begin
      st_next.otw = !st_reg.otw;
      st_next.otw_cnt = 24'h0;
    end
    st_next.pg_cnt = fps_dstep(st_reg.pg_cnt, pg_inside != st_reg.pg, DLY_CYC);
    if (st_reg.pg_cnt == DLY_CYC)
    begin
      st_next.pg = !st_reg.pg;
      st_next.pg_cnt = 24'h0;
    end
    // Shutdown sequencing; a new trip wins over a cause clear.
    case (st_reg.mode)
      ST_RUN:
      begin
        if (trips != 5'h0)
        begin
          st_next.cause = st_next.cause | trips;
          st_next.ot_off = trips[C_OT];
          st_next.retry_cnt = 24'h0;
          st_next.mode = ((trips & st_reg.ctrl[F_LATCH+:5]) != 5'h0) ? ST_LATCH : ST_RETRY;
        end
      end
      ST_RETRY:
      begin
        st_next.retry_cnt = fps_dstep(st_reg.retry_cnt, 1'b1, RETRY_DLY);
        if (st_reg.retry_cnt == RETRY_DLY &&
            !(st_reg.ot_off && $signed(temp_c_i) > OT_ON_C))
        begin
          st_next.mode = ST_RUN;
          st_next.ot_off = 1'b0;
        end
      end
      ST_LATCH:
      begin
        st_next.retry_cnt = (st_next.mode == ST_LATCH) ? 24'h0 : RETRY_DLY;
      end
      default:
      begin
        st_next.mode = ST_RETRY;
      end
    endcase
  end

  always_ff @(posedge ref_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      st_reg <= '0;
      st_reg.ctrl <= CTRL_RST;
      st_reg.mode <= ST_RUN;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  assign awready_o = !st_reg.aw_got && !st_reg.bvalid;
  assign wready_o = !st_reg.w_got && !st_reg.bvalid;
  assign bvalid_o = st_reg.bvalid;
  assign bresp_o = st_reg.bresp;
  assign arready_o = !st_reg.rvalid;
  assign rvalid_o = st_reg.rvalid;
  assign rdata_o = st_reg.rdata;
  assign rresp_o = st_reg.rresp;
  assign turn_off_o = (st_reg.mode != ST_RUN);
  assign power_good_output_o = st_reg.pg;
  assign ot_warning_o = st_reg.otw;

  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!nrst_i);

  sequence s_off_two;
    turn_off_o ##1 turn_off_o;
  endsequence

  sequence s_run_oc;
    run ##0 (iout_pct_i > oc_pct);
  endsequence

  AST_OC_TRIP: assert property (s_run_oc |=> s_off_two)
    else $error("Overcurrent did not turn the output off.");
  AST_OC_RANGE: assert property (oc_pct >= 8'h28 && oc_pct <= 8'h8c)
    else $error("Overcurrent level out of range.");
  AST_OV_FLOOR: assert property (vout_mv_i <= 16'h03e8 |-> !ov_cond)
    else $error("Overvoltage trip below one volt.");
  AST_OV_DELAY: assert property (ov_cond && st_reg.ov_cnt == 24'h0ef |-> ##2 turn_off_o)
    else $error("Overvoltage turn-off not after 240 cycles.");
  AST_UV_RANGE: assert property (uv_pct >= 8'h4b && uv_pct <= 8'h5a)
    else $error("Undervoltage level out of range.");
  AST_OT_DELAY: assert property (run && st_reg.ot_cnt == OT_DLY |=> turn_off_o)
    else $error("Overtemperature turn-off missing.");
  AST_OT_RESTART: assert property (st_reg.mode == ST_RETRY && st_reg.ot_off &&
                                   $signed(temp_c_i) > OT_ON_C |=> turn_off_o)
    else $error("Restart while still hot.");
  AST_TRK_OFF: assert property (!st_reg.ctrl[F_TRK_EN] || !ramp_up_i |=> st_reg.trk_cnt == 24'h0)
    else $error("Tracking armed while disabled.");
  AST_OTW_SET: assert property ($rose(ot_warning_o) |->
                                $past(st_reg.otw_cnt) == DLY_CYC && $past(otw_cond))
    else $error("Warning rose without 240 cycles over threshold.");
  AST_PG_CHG: assert property ($changed(power_good_output_o) |->
                               $past(st_reg.pg_cnt) == DLY_CYC)
    else $error("Power good changed without its delay.");
  AST_RETRY_HOLD: assert property (st_reg.mode == ST_RETRY && st_reg.retry_cnt < RETRY_DLY
                                   |=> turn_off_o)
    else $error("Restart before the retry period.");
endmodule

// ---- shared/fps_pkg.sv ----
/*
  Constants, register map and mode encoding of the fault protection supervisor.
  Assumes a 40 MHz clock; measurements arrive in millivolts, percent and degrees C.
*/
package fps_pkg;
  localparam int CLK_KHZ = 40_000;
  // Detection delays and retry period in their own units.
  localparam int DLY_NS = 6000;
  localparam int OT_DLY_US = 2000;
  localparam int RETRY_MS = 130;
  localparam logic [23:0] DLY_CYC = 24'((DLY_NS * (CLK_KHZ / 1000)) / 1000);
  localparam int OT_DLY_CYC = OT_DLY_US * (CLK_KHZ / 1000);
  localparam int RETRY_CYC = RETRY_MS * CLK_KHZ;
  // Register byte offsets.
  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_STATUS = 4'h4;
  localparam logic [3:0] ADDR_CMD = 4'h8;
  // Control register fields and reset value.
  localparam int F_OC = 0;
  localparam int F_OV = 4;
  localparam int F_UV = 6;
  localparam int F_PG = 8;
  localparam int F_TRK_EN = 9;
  localparam int F_LATCH = 10;
  localparam logic [14:0] CTRL_RST = 15'h002a;
  // Command bits.
  localparam int F_REARM = 0;
  localparam int F_CLR_CAUSE = 1;
  // Cause bit positions, also the latch-select bit order.
  localparam int C_OC = 0;
  localparam int C_OV = 1;
  localparam int C_UV = 2;
  localparam int C_OT = 3;
  localparam int C_TRK = 4;
  // Thresholds.
  localparam int OC_MIN_PCT = 40;
  localparam int OC_STEP = 10;
  localparam logic [3:0] OC_MAXCODE = 4'ha;
  localparam int OV_MIN_PCT = 110;
  localparam int OV_STEP = 10;
  localparam logic [1:0] OV_MAXCODE = 2'h2;
  localparam logic [31:0] OV_FLOOR_X100 = 32'h0001_86a0;
  localparam int UV_MIN_PCT = 75;
  localparam int UV_STEP = 5;
  localparam int PG_LO_PCT = 90;
  localparam int PG_STEP = 5;
  localparam logic [7:0] PG_HI_PCT = 8'h6e;
  localparam logic [16:0] TRK_MV = 17'h000fa;
  localparam logic signed [7:0] OT_OFF_C = 8'sh78;
  localparam logic signed [7:0] OT_ON_C = 8'sh6e;
  localparam logic signed [7:0] OTW_C = 8'sh78;
  localparam logic signed [7:0] OTW_HYS = 8'sh03;
  localparam logic signed [7:0] OTW_CLR_C = OTW_C - OTW_HYS;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [2:0] {
    ST_RUN = 3'h1,
    ST_RETRY = 3'h2,
    ST_LATCH = 3'h4
  } fps_mode_t;
endpackage

// ---- verification/fault_protection_supervisor_tb_top.sv ----
/*
  Self-checking bench of the fault protection supervisor: bus master, measurement stimulus, monitor.
  Assumes fps_pkg and fps_supervisor are compiled first and that the bench is the only bus master.
*/
`timescale 1ns/1ps
`define FPS_CHECK(got, exp) \
  begin \
    n_compared++; \
    if ((got) !== (exp)) \
    begin \
      bad_count++; \
      $display("Error at %0t ns: got %h expected %h", $time, got, exp); \
    end \
  end
module fault_protection_supervisor_tb_top;
  import fps_pkg::*;
  typedef struct packed {
    logic [33:0] v;
    logic [33:0] m;
  } fps_note_t;
  localparam int OT_T = 50;
  localparam int RETRY_T = 100;
  localparam logic [2:0] P_OFF = 3'h4;
  localparam logic [2:0] P_PG = 3'h2;
  localparam logic [2:0] P_WRN = 3'h1;
  localparam logic [33:0] ALL = 34'h3_ffff_ffff;
  localparam logic [15:0] V2K = 16'h07d0;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic ramp = 1'b0, probe = 1'b0;
  logic [3:0] awaddr = 4'h0, araddr = 4'h0;
  logic [31:0] wdata = 32'h0;
  logic [15:0] vout = 16'h03e8, vset = 16'h03e8, vtrack = 16'h03e8;
  logic [7:0] iout = 8'h1e, temp = 8'h19;
  logic awready, wready, bvalid, arready, rvalid, off, pg, warn;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [33:0] got;
  fps_note_t cur;
  fps_note_t note_q[$];
  int bad_count = 0, n_compared = 0, cycles = 0, thr;

  fps_supervisor #(.OT_DLY(24'(OT_T)), .RETRY_DLY(24'(RETRY_T))) DUT (
    .ref_clk_i(clk), .nrst_i(rst_n), .awaddr_i(awaddr), .awvalid_i(awvalid),
    .awready_o(awready), .wdata_i(wdata), .wstrb_i(4'hf), .wvalid_i(wvalid),
    .wready_o(wready), .bresp_o(bresp), .bvalid_o(bvalid), .bready_i(bready),
    .araddr_i(araddr), .arvalid_i(arvalid), .arready_o(arready), .rdata_o(rdata),
    .rresp_o(rresp), .rvalid_o(rvalid), .rready_i(rready), .vout_mv_i(vout),
    .vset_mv_i(vset), .vtrack_mv_i(vtrack), .iout_pct_i(iout), .temp_c_i(temp),
    .ramp_up_i(ramp), .turn_off_o(off), .power_good_output_o(pg), .ot_warning_o(warn));

  always #12.5 clk = ~clk;

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic axw(input logic [3:0] a, input logic [31:0] d, input logic [1:0] r);
    note_q.push_back('{v: {r, 32'h0}, m: {2'h3, 32'h0}});
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge clk);
      if (awready)
        awvalid <= 1'b0;
      if (wready)
        wvalid <= 1'b0;
    end
    while (!bvalid);
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, input logic [33:0] v, input logic [33:0] m);
    note_q.push_back('{v: v, m: m});
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge clk);
      if (arready)
        arvalid <= 1'b0;
    end
    while (!rvalid);
    rready <= 1'b0;
  endtask

  // The monitor samples the pins at the edge after the call; probe is high for one cycle and the task takes two.
  task automatic pin(input logic [2:0] m, input logic [2:0] v);
    note_q.push_back('{v: {31'h0, v}, m: {31'h0, m}});
    probe <= 1'b1;
    @(posedge clk);
    probe <= 1'b0;
    @(posedge clk);
  endtask

  // Apply one operating point long enough for any 6 us trip, then recover.
  task automatic trial(input logic [31:0] c, input logic [15:0] vs, input logic [15:0] vo,
                       input logic [15:0] vt, input logic r, input logic [2:0] e);
    axw(ADDR_CTRL, c, RESP_OKAY);
    vset <= vs;
    vout <= vo;
    vtrack <= vt;
    ramp <= r;
    cyc(250);
    pin(P_OFF, e);
    vout <= vs;
    vtrack <= vs;
    ramp <= 1'b0;
    cyc(2);
    while (off)
      @(posedge clk);
  endtask

  task automatic close_out();
    $display("Comparisons %0d, mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 60000)
    begin
      bad_count++;
      close_out();
    end
  end

  always @(posedge clk)
  begin
    if ((rvalid && rready) || (bvalid && bready) || probe)
    begin
      if (rvalid && rready)
        got = {rresp, rdata};
      else if (bvalid && bready)
        got = {bresp, 32'h0};
      else
        got = {31'h0, off, pg, warn};
      if (note_q.size() == 0)
        bad_count++;
      else
      begin
        cur = note_q.pop_front();
        `FPS_CHECK(got & cur.m, cur.v)
      end
    end
  end

  initial
  begin
    void'($urandom(20895));
    cyc(4);
    rst_n <= 1'b1;
    pin(P_PG, 3'h0);
    rd(ADDR_CTRL, {RESP_OKAY, 17'h0, CTRL_RST}, ALL);
    rd(ADDR_STATUS, 34'h0, 34'h1ff);
    axw(4'hc, 32'h0, RESP_SLVERR);
    rd(4'hc, {RESP_SLVERR, 32'h0}, ALL);
    axw(ADDR_STATUS, 32'hffff_ffff, RESP_OKAY);
    cyc(240);
    pin(P_PG, P_PG);
    vout <= 16'h0398;
    cyc(250);
    pin(P_PG, P_PG);
    axw(ADDR_CTRL, 32'h12a, RESP_OKAY);
    cyc(230);
    pin(P_PG, P_PG);
    cyc(14);
    pin(P_PG, 3'h0);
    rd(ADDR_CTRL, {RESP_OKAY, 32'h12a}, ALL);
    vout <= 16'h0442;
    cyc(250);
    pin(P_PG, P_PG);
    vout <= 16'h0456;
    cyc(250);
    pin(P_PG, 3'h0);
    vout <= 16'h03e8;
    for (int c = 0; c <= int'(OC_MAXCODE); c++)
    begin
      thr = OC_MIN_PCT + OC_STEP * c;
      axw(ADDR_CTRL, 32'h20 | 32'(c), RESP_OKAY);
      iout <= 8'(thr - 1);
      cyc(3);
      pin(P_OFF, 3'h0);
      iout <= 8'(thr + 1 + $urandom_range(3));
      cyc(2);
      pin(P_OFF, P_OFF);
      iout <= 8'h1e;
      cyc(RETRY_T - 10);
      pin(P_OFF, P_OFF);
      cyc(12);
      pin(P_OFF, 3'h0);
    end
    axw(ADDR_CTRL, 32'h42a, RESP_OKAY);
    iout <= 8'h96;
    cyc(3);
    iout <= 8'h1e;
    cyc(RETRY_T + 50);
    pin(P_OFF, P_OFF);
    rd(ADDR_STATUS, {RESP_OKAY, 32'h181}, {2'h3, 32'h181});
    axw(ADDR_CMD, 32'h1, RESP_OKAY);
    cyc(3);
    pin(P_OFF, 3'h0);
    axw(ADDR_CMD, 32'h2, RESP_OKAY);
    rd(ADDR_STATUS, {RESP_OKAY, 32'h0}, {2'h3, 32'h19f});
    for (int c = 0; c <= int'(OV_MAXCODE); c++)
    begin
      thr = (OV_MIN_PCT + OV_STEP * c) * 20;
      trial(32'ha | 32'(c << 4), V2K, 16'(thr - 5), V2K, 1'b0, 3'h0);
      vout <= 16'(thr + 5);
      cyc(236);
      pin(P_OFF, 3'h0);
      cyc(8);
      pin(P_OFF, P_OFF);
      vout <= V2K;
      while (off)
        @(posedge clk);
    end
    trial(32'h0a, 16'h01f4, 16'h03de, 16'h01f4, 1'b0, 3'h0);
    trial(32'h0a, 16'h01f4, 16'h03f2, 16'h01f4, 1'b0, P_OFF);
    for (int c = 0; c < 4; c++)
    begin
      thr = (UV_MIN_PCT + UV_STEP * c) * 20;
      trial(32'h2a | 32'(c << 6), V2K, 16'(thr + 5), V2K, 1'b0, 3'h0);
      trial(32'h2a | 32'(c << 6), V2K, 16'(thr - 5), V2K, 1'b0, P_OFF);
    end
    trial(32'h02a, V2K, V2K, V2K + 16'h012c, 1'b1, 3'h0);
    trial(32'h22a, V2K, V2K, V2K + 16'h00f0, 1'b1, 3'h0);
    trial(32'h22a, V2K, V2K, V2K - 16'h0104, 1'b1, P_OFF);
    trial(32'h22a, V2K, V2K, V2K + 16'h0104, 1'b1, P_OFF);
    trial(32'h22a, V2K, V2K, V2K + 16'h012c, 1'b0, 3'h0);
    axw(ADDR_CTRL, 32'h02a, RESP_OKAY);
    temp <= 8'h78;
    cyc(OT_T - 5);
    pin(P_OFF | P_WRN, 3'h0);
    cyc(10);
    pin(P_OFF, P_OFF);
    cyc(225 - OT_T);
    pin(P_WRN, 3'h0);
    cyc(15);
    pin(P_WRN, P_WRN);
    rd(ADDR_STATUS, {RESP_OKAY, 32'h28}, {2'h3, 32'h28});
    temp <= 8'h76;
    cyc(260);
    pin(P_OFF | P_WRN, P_OFF | P_WRN);
    temp <= 8'h75;
    cyc(260);
    pin(P_OFF | P_WRN, P_OFF);
    temp <= 8'h6e;
    cyc(5);
    pin(P_OFF, 3'h0);
    temp <= 8'h19;
    rst_n <= 1'b0;
    cyc(4);
    rst_n <= 1'b1;
    rd(ADDR_CTRL, {RESP_OKAY, 17'h0, CTRL_RST}, ALL);
    close_out();
  end
endmodule
